// ### brip_bank.sv
// Bridge ROM base, interrupt line/pin and parity response register bank
// Assumes: synchronous inputs, one-cycle strobes, read data one cycle later
//
// Chosen here: strobed register access.
`timescale 1ns/100ps
`include "brip_defs.svh"

module brip_bank
#(
    parameter bit P_USE_INTA = 1'b1
)
(
    // Clock, reset, enable
    input  wire logic                i_clk,
    input  wire logic                i_resetn,
    input  wire logic                i_ce,
    // Register port
    input  wire brip_pkg::brip_addr_t i_addr,
    input  wire brip_pkg::brip_word_t i_wdata,
    input  wire logic                i_wr,
    input  wire logic                i_rd,
    output brip_pkg::brip_word_t      o_rdata,
    // Secondary interface
    input  wire logic [31:0]         i_sec_ad,
    input  wire logic [3:0]          i_sec_cbe,
    input  wire logic                i_sec_addr_phase,
    input  wire logic                i_sec_data_phase,
    input  wire logic                i_sec_master_rd,
    input  wire logic                i_sec_par,
    output logic                     o_sec_par,
    output logic                     o_sec_addr_perr,
    output logic                     o_sec_data_perr,
    output logic                     o_mdpe_set,
    output logic                     o_perr_en,
    // Interrupt
    output logic                     o_irq
);
    import brip_pkg::*;

    // Fixed interrupt pin value, chosen between the two legal codes
    localparam brip_byte_t PIN_VAL = P_USE_INTA ? `BRIP_PIN_INTA : `BRIP_PIN_NONE;

    brip_par_if pif ();

    // Register state
    brip_byte_t line_q, line_d;
    logic       pere_q, pere_d;
    brip_ev_t   sts_q,  sts_d;
    brip_ev_t   msk_q,  msk_d;
    brip_word_t rdat_q, rdat_d;
    // Output state
    logic       par_q,  par_d;
    logic       aerr_q, aerr_d;
    logic       derr_q, derr_d;
    logic       mdpe_q, mdpe_d;
    logic       irq_q,  irq_d;
    brip_ev_t   ev;

    // Address match used by every access path
    function automatic logic hit(input brip_addr_t a, input brip_addr_t off);
        hit = (a == off);
    endfunction

    // Read value for an address; unmapped reads return zero
    function automatic brip_word_t rd_word(input brip_addr_t a);
        brip_word_t w;
        w = 32'h0000_0000;
        if (hit(a, `BRIP_OFF_ROM))
            w = `BRIP_ROM_VAL;
        else if (hit(a, `BRIP_OFF_BCI))
        begin
            w[`BRIP_LINE_LSB +: 8] = line_q;
            w[`BRIP_PIN_LSB +: 8]  = PIN_VAL;
            w[`BRIP_PERE_BIT]      = pere_q;
        end
        else if (hit(a, `BRIP_OFF_ISTS))
            w[2:0] = sts_q;
        else if (hit(a, `BRIP_OFF_IMSK))
            w[2:0] = msk_q;
        rd_word = w;
    endfunction

    // Parity unit hookup
    assign pif.ce         = i_ce;
    assign pif.ad         = i_sec_ad;
    assign pif.cbe        = i_sec_cbe;
    assign pif.addr_phase = i_sec_addr_phase;
    assign pif.data_phase = i_sec_data_phase;
    assign pif.master_rd  = i_sec_master_rd;
    assign pif.par_in     = i_sec_par;

    brip_par_unit u_par
    (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .pif      (pif)
    );

    // Detected errors count as events only when response is enabled
    assign ev = pere_q ? {pif.mdpe_err, pif.data_err, pif.addr_err}
                       : `BRIP_EV_RST;

    // Next values of registers and outputs
    always_comb
    begin
        line_d = line_q;
        pere_d = pere_q;
        sts_d  = sts_q;
        msk_d  = msk_q;
        rdat_d = rdat_q;
        par_d  = par_q;
        aerr_d = aerr_q;
        derr_d = derr_q;
        mdpe_d = mdpe_q;
        irq_d  = irq_q;
        if (i_ce)
        begin
            // Writes; ROM base and pin byte have no storage to change
            if (i_wr && hit(i_addr, `BRIP_OFF_BCI))
            begin
                line_d = i_wdata[`BRIP_LINE_LSB +: 8];
                pere_d = i_wdata[`BRIP_PERE_BIT];
            end
            if (i_wr && hit(i_addr, `BRIP_OFF_IMSK))
                msk_d = i_wdata[2:0];
            // Write one clears, a new event in the same cycle wins
            if (i_wr && hit(i_addr, `BRIP_OFF_ISTS))
                sts_d = sts_q & ~i_wdata[2:0];
            sts_d = sts_d | ev;
            // Read data for the following cycle only
            rdat_d = i_rd ? rd_word(i_addr) : 32'h0000_0000;
            // Secondary side outputs
            par_d  = pif.par_gen;
            aerr_d = ev[`BRIP_EV_ADDR];
            derr_d = ev[`BRIP_EV_DATA];
            mdpe_d = ev[`BRIP_EV_MDPE];
            irq_d  = |(sts_d & msk_d);
        end
    end

    // Registers
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            line_q <= `BRIP_LINE_RST;
            pere_q <= `BRIP_PERE_RST;
            sts_q  <= `BRIP_EV_RST;
            msk_q  <= `BRIP_EV_RST;
            rdat_q <= 32'h0000_0000;
            par_q  <= 1'b0;
            aerr_q <= 1'b0;
            derr_q <= 1'b0;
            mdpe_q <= 1'b0;
            irq_q  <= 1'b0;
        end
        else
        begin
            line_q <= line_d;
            pere_q <= pere_d;
            sts_q  <= sts_d;
            msk_q  <= msk_d;
            rdat_q <= rdat_d;
            par_q  <= par_d;
            aerr_q <= aerr_d;
            derr_q <= derr_d;
            mdpe_q <= mdpe_d;
            irq_q  <= irq_d;
        end
    end

    // Outputs straight from flip-flops
    assign o_rdata         = rdat_q;
    assign o_sec_par       = par_q;
    assign o_sec_addr_perr = aerr_q;
    assign o_sec_data_perr = derr_q;
    assign o_mdpe_set      = mdpe_q;
    assign o_perr_en       = pere_q;
    assign o_irq           = irq_q;

    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    // ROM base read returns zero in the next cycle
    property p_rom_zero;
        i_ce && i_rd && i_addr == `BRIP_OFF_ROM |=> o_rdata == 32'h0000_0000;
    endproperty
    a_rom_zero: assert property (p_rom_zero)
        else $error("ROM base read not zero");

    // Line byte written then read back returns the written value
    property p_line_rw;
        brip_byte_t v;
        (i_ce && i_wr && i_addr == `BRIP_OFF_BCI, v = i_wdata[7:0])
            ##1 (i_ce && i_rd && i_addr == `BRIP_OFF_BCI)
            |=> o_rdata[7:0] == v;
    endproperty
    a_line_rw: assert property (p_line_rw)
        else $error("Interrupt line readback mismatch");

    // Pin byte always reads its fixed code
    property p_pin_val;
        i_ce && i_rd && i_addr == `BRIP_OFF_BCI |=> o_rdata[15:8] == PIN_VAL;
    endproperty
    a_pin_val: assert property (p_pin_val)
        else $error("Interrupt pin value wrong");

    // Pin byte never shows a code other than 00h or 01h
    property p_pin_legal;
        i_ce && i_rd && i_addr == `BRIP_OFF_BCI |=> o_rdata[15:9] == 7'h00;
    endproperty
    a_pin_legal: assert property (p_pin_legal)
        else $error("Interrupt pin holds illegal code");

    // Errors with response disabled leave status and pulses quiet
    property p_ignore;
        i_ce && !pere_q && (pif.addr_err || pif.data_err)
            |=> !o_sec_addr_perr && !o_sec_data_perr && !o_mdpe_set
                && (sts_q == $past(sts_q) || $past(i_wr));
    endproperty
    a_ignore: assert property (p_ignore)
        else $error("Parity error reported while disabled");

    // Parity output follows AD and CBE one cycle later in every mode
    property p_gen;
        i_ce |=> o_sec_par == ^{$past(i_sec_ad), $past(i_sec_cbe)};
    endproperty
    a_gen: assert property (p_gen)
        else $error("Secondary parity not generated");

    // Data errors with response enabled pulse once and stick in status
    property p_report;
        i_ce && pere_q && pif.data_err
            |=> o_sec_data_perr && sts_q[`BRIP_EV_DATA]
                && (o_mdpe_set == $past(pif.mdpe_err));
    endproperty
    a_report: assert property (p_report)
        else $error("Parity error not reported");

    // Writing ROM base or pin byte does not change what they read
    property p_ro_write;
        (i_ce && i_wr && (i_addr == `BRIP_OFF_ROM || i_addr == `BRIP_OFF_BCI))
            ##1 (i_ce && i_rd && i_addr == $past(i_addr))
            |=> (o_rdata[15:8] == PIN_VAL || o_rdata == 32'h0000_0000);
    endproperty
    a_ro_write: assert property (p_ro_write)
        else $error("Read-only field changed by write");

    // Interrupt output tracks unmasked sticky status
    property p_irq;
        ##1 o_irq == |(sts_q & msk_q);
    endproperty
    a_irq: assert property (p_irq)
        else $error("Interrupt output mismatch");

    // Read data fall back to zero when no read was taken
    property p_rd_idle;
        i_ce && !i_rd |=> o_rdata == 32'h0000_0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("Read data not cleared after idle cycle");

    // A reported event stays set even against a clearing write
    property p_ev_wins;
        i_ce && (|ev) |=> (sts_q & $past(ev)) == $past(ev);
    endproperty
    a_ev_wins: assert property (p_ev_wins)
        else $error("Status event lost to clear");

    // Writing ones to status clears those bits when no event arrives
    property p_w1c;
        i_ce && i_wr && i_addr == `BRIP_OFF_ISTS && ev == `BRIP_EV_RST
            |=> (sts_q & $past(i_wdata[2:0])) == `BRIP_EV_RST;
    endproperty
    a_w1c: assert property (p_w1c)
        else $error("Status bit not cleared by write");

    // Low clock enable freezes every register
    property p_freeze;
        !i_ce |=> $stable(line_q) && $stable(pere_q) && $stable(sts_q) && $stable(msk_q)
            && $stable(o_rdata) && $stable(o_sec_par) && $stable(o_irq);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("State changed while clock enable low");

    // Response enable bit follows bit 16 of a 3Ch write
    property p_perr_en;
        i_ce && i_wr && i_addr == `BRIP_OFF_BCI
            |=> o_perr_en == $past(i_wdata[`BRIP_PERE_BIT]);
    endproperty
    a_perr_en: assert property (p_perr_en)
        else $error("Parity response enable not stored");

    // With response disabled no new status bit appears
    property p_no_new;
        i_ce && !pere_q |=> (sts_q & ~$past(sts_q)) == `BRIP_EV_RST;
    endproperty
    a_no_new: assert property (p_no_new)
        else $error("Status set while response disabled");
endmodule

// ### brip_defs.svh
// Offsets, field positions, reset values of the bridge ROM/IRQ/parity bank
// Assumes: included by bare name, byte addresses on an 8-bit port
`ifndef BRIP_DEFS_SVH
`define BRIP_DEFS_SVH

// Register byte offsets
`define BRIP_OFF_ROM   8'h38
`define BRIP_OFF_BCI   8'h3C
`define BRIP_OFF_ISTS  8'h40
`define BRIP_OFF_IMSK  8'h44

// Field positions in the 3Ch word
`define BRIP_LINE_LSB  0
`define BRIP_PIN_LSB   8
`define BRIP_PERE_BIT  16

// Event bit positions in status and mask
`define BRIP_EV_ADDR   0
`define BRIP_EV_DATA   1
`define BRIP_EV_MDPE   2

// Reset and fixed values
`define BRIP_ROM_VAL   32'h0000_0000
`define BRIP_LINE_RST  8'h00
`define BRIP_PIN_INTA  8'h01
`define BRIP_PIN_NONE  8'h00
`define BRIP_PERE_RST  1'b0
`define BRIP_EV_RST    3'h0

`endif

// ### brip_pkg.sv
// Types shared by the bridge ROM/IRQ/parity bank
// Assumes: compiled before every other file of the block
package brip_pkg;
    typedef logic [31:0] brip_word_t;
    typedef logic [7:0]  brip_addr_t;
    typedef logic [7:0]  brip_byte_t;
    typedef logic [2:0]  brip_ev_t;
endpackage

// ### brip_par_if.sv
// Carrier between the register bank and the secondary parity unit
// Assumes: one clock domain, driven by the bank top
`timescale 1ns/100ps
interface brip_par_if;
    logic        ce;
    logic [31:0] ad;
    logic [3:0]  cbe;
    logic        addr_phase;
    logic        data_phase;
    logic        master_rd;
    logic        par_in;
    logic        par_gen;
    logic        addr_err;
    logic        data_err;
    logic        mdpe_err;

    modport unit (input ce, ad, cbe, addr_phase, data_phase, master_rd, par_in,
                  output par_gen, addr_err, data_err, mdpe_err);
    modport bank (output ce, ad, cbe, addr_phase, data_phase, master_rd, par_in,
                  input par_gen, addr_err, data_err, mdpe_err);
endinterface

// ### brip_par_unit.sv
// Secondary bus parity generator and checker
// Assumes: parity for a phase arrives one clock after its AD/CBE values
`timescale 1ns/100ps
module brip_par_unit
(
    // Clock and reset
    input  wire logic  i_clk,
    input  wire logic  i_resetn,
    // Bus side
    brip_par_if.unit   pif
);
    import brip_pkg::*;

    logic par_q, par_d;
    logic adr_q, adr_d;
    logic dat_q, dat_d;
    logic mst_q, mst_d;
    logic miss;

    // Even parity over AD and CBE, always produced
    assign pif.par_gen = ^{pif.ad, pif.cbe};

    // Compare received parity against last phase's expected value
    assign miss         = (pif.par_in != par_q);
    assign pif.addr_err = adr_q & miss;
    assign pif.data_err = dat_q & miss;
    assign pif.mdpe_err = dat_q & mst_q & miss;

    // Next values of the phase history
    always_comb
    begin
        par_d = par_q;
        adr_d = adr_q;
        dat_d = dat_q;
        mst_d = mst_q;
        if (pif.ce)
        begin
            par_d = pif.par_gen;
            adr_d = pif.addr_phase;
            dat_d = pif.data_phase;
            mst_d = pif.master_rd;
        end
    end

    // Phase history registers
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            par_q <= 1'b0;
            adr_q <= 1'b0;
            dat_q <= 1'b0;
            mst_q <= 1'b0;
        end
        else
        begin
            par_q <= par_d;
            adr_q <= adr_d;
            dat_q <= dat_d;
            mst_q <= mst_d;
        end
    end
endmodule

// ### brip_sec_agent.sv
// Secondary bus agent model: drives phases and returns their parity
// Assumes: requests change just after a rising edge of i_clk
`timescale 1ns/100ps
module brip_sec_agent
(
    // Clock, reset
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    // Phase request
    input  wire logic        i_req,
    input  wire logic [1:0]  i_kind,
    input  wire logic [35:0] i_val,
    input  wire logic        i_bad,
    // Bus side
    output logic [35:0]      o_bus,
    output logic             o_addr_ph,
    output logic             o_data_ph,
    output logic             o_mrd,
    output logic             o_par
);
    logic [35:0] idle_q;

    // Idle bus shows a pattern that changes every cycle
    assign o_bus     = i_req ? i_val : idle_q;
    assign o_addr_ph = i_req & (i_kind == 2'h0);
    assign o_data_ph = i_req & (i_kind != 2'h0);
    assign o_mrd     = i_req & (i_kind == 2'h2);

    // Parity one clock after its phase, inverted when asked
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            idle_q <= 36'h0;
            o_par  <= 1'b0;
        end
        else
        begin
            idle_q <= ~idle_q;
            o_par  <= (^o_bus) ^ (i_req & i_bad);
        end
    end
endmodule

// ### tb_brip_bank.sv
// Self-checking bench of the ROM/IRQ/parity register bank
// Assumes: design files and the agent model compiled first
`timescale 1ns/100ps
`include "brip_defs.svh"
module tb_brip_bank;
    import brip_pkg::*;
    logic        clk, resetn, ce, wr, rd, req, bad;
    logic        aph, dph, mrd, spar, par_o, aerr, derr, mdpe, pen, irq;
    brip_addr_t  addr;
    brip_word_t  wdata, rdata, rdata_n, w, r;
    logic [1:0]  kind;
    logic [35:0] val, bus;
    logic [2:0]  st, msk;
    int          n_fail, compares, seed, i;

    brip_bank u_brip_bank (.i_clk(clk), .i_resetn(resetn), .i_ce(ce),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_sec_ad(bus[31:0]), .i_sec_cbe(bus[35:32]), .i_sec_addr_phase(aph),
        .i_sec_data_phase(dph), .i_sec_master_rd(mrd), .i_sec_par(spar),
        .o_sec_par(par_o), .o_sec_addr_perr(aerr), .o_sec_data_perr(derr),
        .o_mdpe_set(mdpe), .o_perr_en(pen), .o_irq(irq));
    // Second bank reports no legacy interrupt
    brip_bank #(.P_USE_INTA(1'b0)) u_brip_bank_none (.i_clk(clk),
        .i_resetn(resetn), .i_ce(ce), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata_n), .i_sec_ad(bus[31:0]),
        .i_sec_cbe(bus[35:32]), .i_sec_addr_phase(aph), .i_sec_data_phase(dph),
        .i_sec_master_rd(mrd), .i_sec_par(spar), .o_sec_par(),
        .o_sec_addr_perr(), .o_sec_data_perr(), .o_mdpe_set(), .o_perr_en(),
        .o_irq());
    brip_sec_agent u_brip_sec_agent (.i_clk(clk), .i_resetn(resetn),
        .i_req(req), .i_kind(kind), .i_val(val), .i_bad(bad), .o_bus(bus),
        .o_addr_ph(aph), .o_data_ph(dph), .o_mrd(mrd), .o_par(spar));

    // Expected 3Ch word
    function automatic brip_word_t bci(input brip_word_t v, input brip_byte_t p);
        return {15'h0, v[16], p, v[7:0]};
    endfunction

    task automatic chk_w(input brip_word_t got, input brip_word_t exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_b(input logic got, input logic exp);
        chk_w({31'h0, got}, {31'h0, exp});
    endtask

    task automatic wr_reg(input brip_addr_t a, input brip_word_t d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    // Write then read back with no gap between the strobes
    task automatic wr_rd(input brip_addr_t a, input brip_word_t d, output brip_word_t q);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr    <= 1'b0;
        rd    <= 1'b1;
        @(posedge clk);
        rd    <= 1'b0;
        #1 q = rdata;
    endtask

    task automatic rd_reg(input brip_addr_t a, output brip_word_t d);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask

    // One secondary phase; kind 0 address, 1 data, 2 master read data
    task automatic sec(input logic [1:0] k, input logic b);
        logic [35:0] v;
        v = {4'($random(seed)), 32'($random(seed))};
        @(posedge clk);
        req  <= 1'b1;
        kind <= k;
        val  <= v;
        bad  <= b;
        @(posedge clk);
        req  <= 1'b0;
        #1 chk_b(par_o, ^v);
        @(posedge clk);
        #1 chk_b(aerr, pen & b & (k == 2'h0));
        chk_b(derr, pen & b & (k != 2'h0));
        chk_b(mdpe, pen & b & (k == 2'h2));
        if (pen & b)
            st = st | ((k == 2'h0) ? 3'h1 : (k == 2'h1) ? 3'h2 : 3'h6);
        chk_b(irq, |(st & msk));
    endtask

    task automatic chk_irq();
        repeat (2) @(posedge clk);
        #1 chk_b(irq, |(st & msk));
        rd_reg(`BRIP_OFF_ISTS, r);
        chk_w(r, {29'h0, st});
    endtask

    task automatic finish_test();
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Clock
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Watchdog
    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        finish_test();
    end

    // Main sequence
    initial
    begin
        seed = 32'h0000_6e10;
        {n_fail, compares} = '0;
        {resetn, wr, rd, req, bad, addr, wdata, kind, val, st, msk} = '0;
        ce = 1'b1;
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        rd_reg(`BRIP_OFF_BCI, r);
        chk_w(r, bci(32'h0, 8'h01));
        chk_w(rdata_n, bci(32'h0, 8'h00));
        rd_reg(8'h50, r);
        chk_w(r, 32'h0);
        chk_irq();
        for (i = 0; i < 8; i++)
        begin
            w = (i == 0) ? 32'hFFFF_FFFF : $random(seed);
            wr_rd(`BRIP_OFF_ROM, w, r);
            chk_w(r, 32'h0);
            wr_rd(`BRIP_OFF_BCI, w, r);
            chk_w(r, bci(w, 8'h01));
            chk_w(rdata_n, bci(w, 8'h00));
            chk_b(pen, w[16]);
        end
        // Frozen clock enable blocks a write
        wr_reg(`BRIP_OFF_BCI, 32'h0000_005A);
        ce <= 1'b0;
        wr_reg(`BRIP_OFF_BCI, 32'h0001_00C3);
        ce <= 1'b1;
        rd_reg(`BRIP_OFF_BCI, r);
        chk_w(r, bci(32'h0000_005A, 8'h01));
        $display("test registers done");
        wr_reg(`BRIP_OFF_IMSK, 32'h0000_0007);
        msk = 3'h7;
        for (i = 0; i < 30; i++)
        begin
            if (i == 0 || i == 15)
                wr_reg(`BRIP_OFF_BCI, (i == 0) ? 32'h0 : 32'h0001_0000);
            sec(2'(i % 3), (i < 6 || (i >= 15 && i < 21)) ? 1'b1 : 1'($random(seed)));
            if (i == 14 || i == 29)
                chk_irq();
        end
        $display("test parity done");
        wr_reg(`BRIP_OFF_IMSK, 32'h0);
        msk = 3'h0;
        chk_irq();
        wr_reg(`BRIP_OFF_IMSK, 32'h0000_0004);
        msk = 3'h4;
        wr_reg(`BRIP_OFF_ISTS, 32'h0000_0004);
        st = st & 3'h3;
        chk_irq();
        wr_reg(`BRIP_OFF_ISTS, 32'h0000_0007);
        st = 3'h0;
        chk_irq();
        $display("test interrupt done");
        finish_test();
    end
endmodule
